// File: core/wrr_defs.svh
// Constants for the weighted round robin initial count register bank
// Functional notes
// - Counts for ports 0-3 at 0x890, 4-7 at 0x894, 8-11 at 0x898.
// - Lowest port of a register in bits 7:0, then 15:8, 23:16, 31:24.
// - Reset loads 0xFF into the field of this instance's own port.
// - Reset loads zero into every field of any other port.
// - Each field seeds its own port's weighted round robin counter.
`ifndef WRR_DEFS_SVH
`define WRR_DEFS_SVH

`define WRR_NUM_PORTS      12
`define WRR_FIELDS_PER_REG 4
`define WRR_FIELD_W        8
`define WRR_ADDR_W         12

`define WRR_OFF_P0_3       12'h890
`define WRR_OFF_P4_7       12'h894
`define WRR_OFF_P8_11      12'h898
`define WRR_OFF_STATUS     12'h8C0

`define WRR_OWN_RESET      8'hFF
`define WRR_OTHER_RESET    8'h00
`define WRR_WORD_ZERO      32'h0000_0000
`define WRR_STATUS_W       12

`define AHB_TRANS_NONSEQ   2'h2
`define AHB_TRANS_SEQ      2'h3
`define AHB_SIZE_WORD      3'h2
`define AHB_RESP_OKAY      1'h0

`endif

// File: core/wrr_pkg.sv
// Types shared by the weighted round robin initial count bank
package wrr_pkg;

  typedef logic [7:0] count_t;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_P0_3   = 3'b001,
    SEL_P4_7   = 3'b010,
    SEL_P8_11  = 3'b011,
    SEL_STATUS = 3'b100
  } reg_sel_t;

endpackage

// File: core/wrr_port_counter.sv
// One port's weighted round robin arbitration counter
`timescale 1ns/1ns
`include "wrr_defs.svh"
module wrr_port_counter
  import wrr_pkg::*;
(
  input  wire logic   hclk,
  input  wire logic   hresetn,
  input  wire count_t start_count,
  input  wire logic   reload,
  input  wire logic   grant,
  output count_t      count,
  output logic        expired
);

  count_t count_reg;
  count_t count_next;

  // Reload wins over a grant in the same cycle, so a fresh round is never
  // shortened by a stale grant
  always_comb begin
    count_next = count_reg;
    if (reload) begin
      count_next = start_count;
    end else if (grant && (count_reg != `WRR_OTHER_RESET)) begin
      count_next = count_reg - 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= `WRR_OTHER_RESET;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count   = count_reg;
  assign expired = (count_reg == `WRR_OTHER_RESET);

endmodule

// File: core/wrr_port_arb_initial_counts.sv
// Initial count register bank and per-port counters, AHB-Lite slave
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/1ns
`include "wrr_defs.svh"
module wrr_port_arb_initial_counts
  import wrr_pkg::*;
#(
  parameter int OWN_PORT = 0
)
(
  // Clock and asynchronous reset, shared by the bus and the counters
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // AHB-Lite slave port, zero wait states
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata,
  // Arbiter side: per-port reload and grant strobes on the same clock
  input  wire logic [11:0]  port_reload,
  input  wire logic [11:0]  port_grant,
  // Per-port counter state seen by the arbiter
  output logic [11:0]       port_expired,
  output logic [95:0]       port_count
);

  // Start counts, one per port, packed four to a register word
  count_t   start_reg  [`WRR_NUM_PORTS];
  count_t   start_next [`WRR_NUM_PORTS];
  count_t   cnt_out    [`WRR_NUM_PORTS];

  // Data phase state of a pending word write
  logic     wr_pend_reg;
  logic     wr_pend_next;
  reg_sel_t wr_sel_reg;
  reg_sel_t wr_sel_next;
  logic [`WRR_NUM_PORTS-1:0] field_we;

  // Read data register; it holds between reads
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;

  // Address phase qualifiers
  logic     addr_phase;
  logic     addr_write;
  logic     addr_read;
  reg_sel_t addr_sel;

  // Reset value of a field depends only on whether it is this port's own
  function automatic count_t field_reset(input int idx);
    if (idx == OWN_PORT) begin
      return `WRR_OWN_RESET;
    end
    return `WRR_OTHER_RESET;
  endfunction

  // Bit position of field f inside its register word
  function automatic int field_lsb(input int f);
    return f * `WRR_FIELD_W;
  endfunction

  // One count field of a bus word
  function automatic count_t word_field(input logic [31:0] w, input int f);
    return w[field_lsb(f) +: `WRR_FIELD_W];
  endfunction

  // Only the low address bits are decoded; the bank aliases above them
  function automatic reg_sel_t decode(input logic [`WRR_ADDR_W-1:0] a);
    case (a)
      `WRR_OFF_P0_3:   return SEL_P0_3;
      `WRR_OFF_P4_7:   return SEL_P4_7;
      `WRR_OFF_P8_11:  return SEL_P8_11;
      `WRR_OFF_STATUS: return SEL_STATUS;
      default:         return SEL_NONE;
    endcase
  endfunction

  // Port number of the first field of a count register select
  function automatic int sel_base(input reg_sel_t s);
    case (s)
      SEL_P4_7:  return `WRR_FIELDS_PER_REG;
      SEL_P8_11: return 2 * `WRR_FIELDS_PER_REG;
      default:   return 0;
    endcase
  endfunction

  // True for the three count registers; status and holes are not
  function automatic logic is_count_sel(input reg_sel_t s);
    return (s == SEL_P0_3) || (s == SEL_P4_7) || (s == SEL_P8_11);
  endfunction

  // Gather the four fields of one count register into a bus word
  function automatic logic [31:0] pack_word(
    input count_t src [`WRR_NUM_PORTS],
    input int     base
  );
    logic [31:0] w;
    w = `WRR_WORD_ZERO;
    for (int f = 0; f < `WRR_FIELDS_PER_REG; f++) begin
      w[field_lsb(f) +: `WRR_FIELD_W] = src[base + f];
    end
    return w;
  endfunction

  // Status word: one expired flag per port in the low bits, the rest zero
  function automatic logic [31:0] status_word(
    input logic [`WRR_STATUS_W-1:0] expired
  );
    logic [31:0] w;
    w = `WRR_WORD_ZERO;
    w[`WRR_STATUS_W-1:0] = expired;
    return w;
  endfunction

  assign addr_phase = hsel && hready &&
                      ((htrans == `AHB_TRANS_NONSEQ) ||
                       (htrans == `AHB_TRANS_SEQ));
  assign addr_sel   = decode(haddr[`WRR_ADDR_W-1:0]);
  // Sub-word writes are dropped; reads of any size return the whole word
  assign addr_write = addr_phase && hwrite && (hsize == `AHB_SIZE_WORD);
  assign addr_read  = addr_phase && !hwrite;

  // Bus control: address phase captured, write data applied next cycle
  always_comb begin
    wr_pend_next = 1'b0;
    wr_sel_next  = SEL_NONE;
    if (addr_write) begin
      wr_pend_next = 1'b1;
      wr_sel_next  = addr_sel;
    end
  end

  // The write lands one edge after its address phase, when hwdata arrives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg  <= SEL_NONE;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_sel_reg  <= wr_sel_next;
    end
  end

  // Count fields: a whole-word write replaces all four fields of a register.
  // Writing zero into the own port's field is not blocked here; the
  // counter would then sit expired after every reload.
  always_comb begin
    field_we = {`WRR_NUM_PORTS{1'b0}};
    if (wr_pend_reg && is_count_sel(wr_sel_reg)) begin
      for (int f = 0; f < `WRR_FIELDS_PER_REG; f++) begin
        field_we[sel_base(wr_sel_reg) + f] = 1'b1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `WRR_NUM_PORTS; i++) begin
      start_next[i] = start_reg[i];
      if (field_we[i]) begin
        start_next[i] = word_field(hwdata, i % `WRR_FIELDS_PER_REG);
      end
    end
  end

  // Own field resets to a full count, every other field to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `WRR_NUM_PORTS; i++) begin
        start_reg[i] <= field_reset(i);
      end
    end else begin
      for (int i = 0; i < `WRR_NUM_PORTS; i++) begin
        start_reg[i] <= start_next[i];
      end
    end
  end

  // Read data is built from the next values so a read right after a
  // write to the same register returns the new word without a wait state
  always_comb begin
    int base;
    base        = sel_base(addr_sel);
    hrdata_next = hrdata_reg;
    if (addr_read) begin
      hrdata_next = `WRR_WORD_ZERO;
      if (is_count_sel(addr_sel)) begin
        hrdata_next = pack_word(start_next, base);
      end else if (addr_sel == SEL_STATUS) begin
        hrdata_next = status_word(port_expired);
      end
    end
  end

  // hrdata moves only on a read address phase, so it stands past the
  // data phase and a master may sample it late
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= `WRR_WORD_ZERO;
    end else begin
      hrdata_reg <= hrdata_next;
    end
  end

  assign hrdata    = hrdata_reg;
  // Every register is a plain flop, so no access ever needs a wait state
  assign hreadyout = 1'b1;
  assign hresp     = `AHB_RESP_OKAY;

  // One counter per port, each seeded from its own field
  for (genvar p = 0; p < `WRR_NUM_PORTS; p++) begin : g_port
    wrr_port_counter u_counter (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .start_count (start_reg[p]),
      .reload      (port_reload[p]),
      .grant       (port_grant[p]),
      .count       (cnt_out[p]),
      .expired     (port_expired[p])
    );
    // Port p occupies its own byte lane of the packed count bus
    assign port_count[p*`WRR_FIELD_W +: `WRR_FIELD_W] = cnt_out[p];
  end

endmodule

// File: bench/wrr_checker_assertions.sv
// Port-level checker for the initial count bank and port 0 counter
`timescale 1ns/1ns
module wrr_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic [11:0] port_reload,
  input wire logic [11:0] port_grant,
  input wire logic [11:0] port_expired,
  input wire logic [95:0] port_count
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_gap_read;
    hsel && htrans[1] && !hwrite && haddr[11:0] == 12'h8A0;
  endsequence
  sequence s_idle0;
    !port_reload[0] && !port_grant[0];
  endsequence
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus stalled");
  property p_gap; s_gap_read |=> hrdata == 32'h0000_0000; endproperty
  a_gap: assert property (p_gap) else $error("gap read");
  property p_dec;
    port_grant[0] && !port_reload[0] && port_count[7:0] != 8'h00
      |=> port_count[7:0] == $past(port_count[7:0]) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("no decrement");
  // A register write alone must never move a running counter
  property p_hold; s_idle0 |=> $stable(port_count[7:0]); endproperty
  a_hold: assert property (p_hold) else $error("count moved");
  property p_exp; port_expired[0] == (port_count[7:0] == 8'h00); endproperty
  a_exp: assert property (p_exp) else $error("expired wrong");
  // A grant on an expired counter is ignored; it must not wrap around
  sequence s_grant_at_zero0;
    port_grant[0] && !port_reload[0] && port_count[7:0] == 8'h00;
  endsequence
  property p_floor;
    s_grant_at_zero0 |=> port_count[7:0] == 8'h00;
  endproperty
  a_floor: assert property (p_floor) else $error("count wrapped");
endmodule
bind wrr_port_arb_initial_counts wrr_checker i_wrr_checker (.hclk, .hresetn,
  .hsel, .haddr, .htrans, .hwrite, .hreadyout, .hresp, .hrdata,
  .port_reload, .port_grant, .port_expired, .port_count);

// File: bench/tb_top.sv
// Register and counter bench for the initial count bank
`timescale 1ns/1ns
module tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [11:0] port_reload = 12'h000;
  logic [11:0] port_grant = 12'h000;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [11:0] port_expired;
  logic [95:0] port_count;
  int          bad_count = 0;
  int          checks = 0;
  // Own port 5 puts the 0xFF default in the middle register
  wrr_port_arb_initial_counts #(.OWN_PORT(5)) i_wrr_port_arb_initial_counts (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .port_reload, .port_grant, .port_expired, .port_count);
  initial begin
    forever #25 hclk = ~hclk;
  end
  task end_of_test;
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [95:0] got, input logic [95:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wait_rdy;
    repeat (20) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    bad_count++;
    end_of_test();
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(96'(hrdata), 96'(e));
  endtask
  // Counters are compared one edge after the pulse has landed
  task pulse(input logic [11:0] r, input logic [11:0] g);
    port_reload <= r;
    port_grant <= g;
    @(posedge hclk);
    port_reload <= 12'h000;
    port_grant <= 12'h000;
    @(posedge hclk);
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'h890, 32'h0000_0000);
    rd(12'h894, 32'h0000_FF00);
    rd(12'h898, 32'h0000_0000);
    pulse(12'hFFF, 12'h000);
    chk(port_count, 96'h0000_0000_0000_FF00_0000_0000);
    xfer(1'b1, 12'h890, 32'h0403_0201);
    // Own port 5 sits in bits 15:8 here and never gets a zero count
    xfer(1'b1, 12'h894, 32'h0807_0605);
    xfer(1'b1, 12'h898, 32'h0C0B_0A09);
    xfer(1'b1, 12'h8A0, 32'hFFFF_FFFF);
    rd(12'h8A0, 32'h0000_0000);
    rd(12'h894, 32'h0807_0605);
    chk(port_count, 96'h0000_0000_0000_FF00_0000_0000);
    pulse(12'hFFF, 12'h000);
    chk(port_count, 96'h0C0B_0A09_0807_0605_0403_0201);
    pulse(12'h000, 12'hFFF);
    pulse(12'h000, 12'hFFF);
    chk(port_count, 96'h0A09_0807_0605_0403_0201_0000);
    chk(96'(port_expired), 96'h003);
    rd(12'h8C0, 32'h0000_0003);
    pulse(12'h001, 12'h001);
    chk(port_count, 96'h0A09_0807_0605_0403_0201_0001);
    // A reset in mid-run must discard the written counts
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(12'h890, 32'h0000_0000);
    rd(12'h894, 32'h0000_FF00);
    rd(12'h898, 32'h0000_0000);
    rd(12'h8C0, 32'h0000_0FFF);
    chk(port_count, 96'h0000_0000_0000_0000_0000_0000);
    end_of_test();
  end
endmodule
